// ==== hdl/lpcd_pkg.sv ====
package lpcd_pkg;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_WAVE_NS = 10_000_000;
    localparam int RELAY_SETTLE_NS = 20_000_000;
    localparam int MIRROR_TIMEOUT_NS = 1_000_000_000;
    localparam int HALF_WAVE_CYC = HALF_WAVE_NS / CLK_PERIOD_NS;
    localparam int RELAY_SETTLE_CYC = RELAY_SETTLE_NS / CLK_PERIOD_NS;
    localparam int MIRROR_TIMEOUT_CYC = MIRROR_TIMEOUT_NS / CLK_PERIOD_NS;

    // ==========================================
    // phase counter
    localparam int PULSE_LOG2 = 12;
    localparam int TW = 27;
    localparam int PW = 13;
    localparam logic [PW-1:0] PHASE_RST = 13'h1000;
    localparam logic [PULSE_LOG2-1:0] CNT_MAX = 12'hfff;

    // ==========================================
    // register map
    localparam int AW = 3;
    localparam int DW = 32;
    localparam logic [AW-1:0] REG_CTRL = 3'h0;
    localparam logic [AW-1:0] REG_PHASE = 3'h1;
    localparam logic [AW-1:0] REG_STATUS = 3'h2;
    localparam logic [AW-1:0] REG_MASK = 3'h3;
    localparam logic [AW-1:0] REG_STATE = 3'h4;
    localparam logic [AW-1:0] REG_LINEV = 3'h5;
    localparam logic [AW-1:0] REG_HALF = 3'h6;

    localparam int CTRL_W = 3;
    localparam int CTRL_LAMP_EN = 0;
    localparam int CTRL_ECONOMY = 1;
    localparam int CTRL_RETAIN_OFF = 2;
    localparam int CTRL_RESTORE = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

    localparam int EVN = 6;
    localparam int EV_ZC = 0;
    localparam int EV_LAMP_FAIL = 1;
    localparam int EV_OVERCUR = 2;
    localparam int EV_FAILOVER = 3;
    localparam int EV_STANDBY = 4;
    localparam int EV_SLOT = 5;

    localparam int ST_LAMP_ON = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_SLOT = 2;
    localparam int ST_BRIGHT = 3;
    localparam int ST_OC = 4;
    localparam int ST_FSM = 8;

    // ==========================================
    // types
    typedef enum logic [5:0] {
        LPCD_IDLE = 6'h01,
        LPCD_MIRROR = 6'h02,
        LPCD_RELAY = 6'h04,
        LPCD_LED = 6'h08,
        LPCD_DONE = 6'h10,
        LPCD_BACK = 6'h20
    } lpcd_fsm_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } lpcd_bus_t;

    typedef struct packed {
        logic zeroCross;
        logic current;
        logic overCurrent;
        logic mirrorAtSecond;
        logic [2:0] slot;
        logic brightness;
        logic standby;
    } lpcd_pins_t;

endpackage

// ==== hdl/lpcd_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module lpcd_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lpcd_sync_t;

    lpcd_sync_t s;
    lpcd_sync_t next_s;

    always_comb begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.s2;

endmodule
`default_nettype wire

// ==== hdl/lpcd_phase_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

module lpcd_phase_timer import lpcd_pkg::*; #(
    parameter int HALF_INIT = HALF_WAVE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic zcLevel,
    input wire logic [PW-1:0] phase,
    input wire logic enable,
    // results
    output logic trigger,
    output logic gate,
    output logic zcPulse,
    output logic [TW-1:0] halfLen
);

    typedef struct packed {
        logic zcPrev;
        logic [TW-1:0] period;
        logic [TW-1:0] halfLen;
        logic [TW-1:0] div;
        logic [PULSE_LOG2-1:0] count;
        logic [PW-1:0] cap;
        logic fired;
        logic trigger;
        logic gate;
        logic zcPulse;
    } lpcd_timer_t;

    lpcd_timer_t s;
    lpcd_timer_t next_s;
    logic [TW-1:0] step;
    logic [TW-1:0] stepM1;

    // cycles per counting pulse, at least one
    assign step = s.halfLen >> PULSE_LOG2;
    assign stepM1 = (step == '0) ? '0 : step - 1'b1;

    always_comb begin
        next_s = s;
        next_s.trigger = 1'b0;
        next_s.zcPulse = 1'b0;
        next_s.zcPrev = zcLevel;
        if (s.period != '1) begin
            next_s.period = s.period + 1'b1;
        end
        if (zcLevel != s.zcPrev) begin
            next_s.zcPulse = 1'b1;
            next_s.halfLen = s.period;
            next_s.period = '0;
            next_s.div = '0;
            next_s.count = '0;
            next_s.cap = phase;
            next_s.fired = 1'b0;
            next_s.gate = 1'b0;
        end else begin
            if (s.div >= stepM1) begin
                next_s.div = '0;
                if (s.count != CNT_MAX) begin
                    next_s.count = s.count + 1'b1;
                end
            end else begin
                next_s.div = s.div + 1'b1;
            end
            // a value of 4096 or more never matches
            if (enable && !s.fired && {1'b0, s.count} == s.cap) begin
                next_s.fired = 1'b1;
                next_s.trigger = 1'b1;
                next_s.gate = 1'b1;
            end
        end
        if (!enable) begin
            next_s.trigger = 1'b0;
            next_s.gate = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.halfLen <= TW'(HALF_INIT);
            s.cap <= PHASE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign trigger = s.trigger;
    assign gate = s.gate;
    assign zcPulse = s.zcPulse;
    assign halfLen = s.halfLen;

endmodule
`default_nettype wire

// ==== hdl/lpcd_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module lpcd_top import lpcd_pkg::*; #(
    parameter int HALF_WAVE_CYCLES = HALF_WAVE_CYC,
    parameter int RELAY_SETTLE_CYCLES = RELAY_SETTLE_CYC,
    parameter int MIRROR_TIMEOUT_CYCLES = MIRROR_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire lpcd_bus_t bus,
    output logic [DW-1:0] rdata,
    // mains side
    input wire logic zeroCross,
    input wire logic lampCurrentSense,
    input wire logic overCurrent,
    output logic triacTrigger,
    output logic lampGate,
    // dual lamp module
    input wire logic mirrorAtSecond,
    output logic mirrorToSecond,
    output logic mirrorToFirst,
    output logic lampSelectRelay,
    output logic secondLampLed,
    output logic lampOnLed,
    // accessory slot and panel
    input wire logic [2:0] slotLines,
    input wire logic brightnessSwitch,
    input wire logic standbyButton,
    output logic reducedSupplyRelay,
    // line voltage from on-chip converter
    input wire logic [7:0] lineVoltageSample,
    // interrupt
    output logic irq
);

    // ==========================================
    // state
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [PW-1:0] phase;
        logic [EVN-1:0] status;
        logic [EVN-1:0] mask;
        logic [DW-1:0] rdata;
        lpcd_fsm_t fsm;
        logic [TW-1:0] timer;
        logic activeLamp;
        logic mirrorToSecond;
        logic mirrorToFirst;
        logic relay;
        logic led2;
        logic lampOnLed;
        logic reducedRelay;
        logic irq;
        logic halfFired;
        logic halfCurrent;
        logic ocPrev;
        logic slotPrev;
        logic standbyPrev;
    } lpcd_state_t;

    lpcd_state_t s;
    lpcd_state_t next_s;

    lpcd_pins_t rawPins;
    lpcd_pins_t pins;
    logic [$bits(lpcd_pins_t)-1:0] pinsVec;

    logic tTrigger;
    logic tGate;
    logic tZc;
    logic [TW-1:0] tHalf;
    logic timerEn;

    // ==========================================
    // pin synchronisers
    // slot lines idle high; they are kept inverted so that the
    // cleared synchroniser reads as an empty slot after reset
    assign rawPins = '{
        zeroCross: zeroCross,
        current: lampCurrentSense,
        overCurrent: overCurrent,
        mirrorAtSecond: mirrorAtSecond,
        slot: ~slotLines,
        brightness: brightnessSwitch,
        standby: standbyButton
    };

    lpcd_sync #(
        .W($bits(lpcd_pins_t))
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d(rawPins),
        .q(pinsVec)
    );

    assign pins = lpcd_pins_t'(pinsVec);

    // ==========================================
    // phase-cut counter
    // overcurrent or a latched trip keeps the triac dark
    assign timerEn = s.ctrl[CTRL_LAMP_EN]
        && !pins.overCurrent
        && !s.status[EV_OVERCUR];

    lpcd_phase_timer #(
        .HALF_INIT(HALF_WAVE_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .zcLevel(pins.zeroCross),
        .phase(s.phase),
        .enable(timerEn),
        .trigger(tTrigger),
        .gate(tGate),
        .zcPulse(tZc),
        .halfLen(tHalf)
    );

    // ==========================================
    // next state
    always_comb begin
        logic [EVN-1:0] ev;
        logic [EVN-1:0] clr;
        logic slotIn;
        logic restore;
        logic lampFail;
        ev = '0;
        clr = '0;
        // all three lines low means an accessory is present
        slotIn = (pins.slot == '1);
        restore = 1'b0;
        lampFail = 1'b0;
        next_s = s;
        next_s.rdata = '0;

        // register writes
        if (bus.wr) begin
            case (bus.addr)
                REG_CTRL: begin
                    next_s.ctrl = bus.wdata[CTRL_W-1:0];
                    // restore is a one-cycle pulse and is never stored
                    restore = bus.wdata[CTRL_RESTORE];
                end
                REG_PHASE: begin
                    next_s.phase = bus.wdata[PW-1:0];
                end
                REG_STATUS: begin
                    clr = bus.wdata[EVN-1:0];
                end
                REG_MASK: begin
                    next_s.mask = bus.wdata[EVN-1:0];
                end
                default: begin
                end
            endcase
        end

        // lamp current over each half wave
        if (tGate) begin
            next_s.halfFired = 1'b1;
            if (pins.current) begin
                next_s.halfCurrent = 1'b1;
            end
        end
        if (tZc) begin
            ev[EV_ZC] = 1'b1;
            next_s.lampOnLed = s.halfCurrent;
            // fired but no current seen: the lamp is dead
            lampFail = s.halfFired && !s.halfCurrent;
            next_s.halfFired = 1'b0;
            next_s.halfCurrent = 1'b0;
        end
        ev[EV_LAMP_FAIL] = lampFail;

        // overcurrent edge
        next_s.ocPrev = pins.overCurrent;
        if (pins.overCurrent && !s.ocPrev) begin
            ev[EV_OVERCUR] = 1'b1;
        end

        // accessory slot and buttons
        next_s.slotPrev = slotIn;
        if (slotIn != s.slotPrev) begin
            ev[EV_SLOT] = 1'b1;
        end
        // panel buttons are dead while an accessory drives the lamp
        next_s.standbyPrev = pins.standby;
        if (pins.standby && !s.standbyPrev && !slotIn) begin
            ev[EV_STANDBY] = 1'b1;
        end
        next_s.reducedRelay = slotIn && s.ctrl[CTRL_ECONOMY];

        // failover sequence
        if (s.timer != '0) begin
            next_s.timer = s.timer - 1'b1;
        end
        case (s.fsm)
            LPCD_IDLE: begin
                // only lamp one can fail over; the mirror moves first
                if (lampFail && !s.activeLamp) begin
                    next_s.fsm = LPCD_MIRROR;
                    next_s.mirrorToSecond = 1'b1;
                    next_s.timer = TW'(MIRROR_TIMEOUT_CYCLES);
                end
            end
            LPCD_MIRROR: begin
                // a stalled mirror motor gives up after the timeout
                if (pins.mirrorAtSecond || s.timer == '0) begin
                    next_s.fsm = LPCD_RELAY;
                    next_s.mirrorToSecond = 1'b0;
                    next_s.relay = 1'b1;
                    next_s.timer = TW'(RELAY_SETTLE_CYCLES);
                end
            end
            LPCD_RELAY: begin
                // relay contacts settle before the led goes on
                if (s.timer == '0) begin
                    next_s.fsm = LPCD_LED;
                    next_s.led2 = 1'b1;
                end
            end
            LPCD_LED: begin
                // record lamp two as the lamp in use
                next_s.fsm = LPCD_DONE;
                next_s.activeLamp = 1'b1;
                ev[EV_FAILOVER] = 1'b1;
            end
            LPCD_DONE: begin
                // the stored lamp holds until a restore pulse arrives with retention off
                if (restore && s.ctrl[CTRL_RETAIN_OFF]) begin
                    next_s.fsm = LPCD_BACK;
                    next_s.relay = 1'b0;
                    next_s.led2 = 1'b0;
                    next_s.mirrorToFirst = 1'b1;
                    next_s.timer = TW'(MIRROR_TIMEOUT_CYCLES);
                end
            end
            LPCD_BACK: begin
                // mirror off the second position again, or motor given up on
                if (!pins.mirrorAtSecond || s.timer == '0) begin
                    next_s.fsm = LPCD_IDLE;
                    next_s.mirrorToFirst = 1'b0;
                    next_s.activeLamp = 1'b0;
                end
            end
            default: begin
                next_s.fsm = LPCD_IDLE;
                next_s.mirrorToSecond = 1'b0;
                next_s.mirrorToFirst = 1'b0;
            end
        endcase

        // sticky status, a new event beats the clear
        next_s.status = (s.status & ~clr) | ev;
        next_s.irq = |(next_s.status & next_s.mask);

        // register reads, answered next cycle
        if (bus.rd) begin
            case (bus.addr)
                REG_CTRL: begin
                    next_s.rdata = DW'(s.ctrl);
                end
                REG_PHASE: begin
                    next_s.rdata = DW'(s.phase);
                end
                REG_STATUS: begin
                    next_s.rdata = DW'(s.status);
                end
                REG_MASK: begin
                    next_s.rdata = DW'(s.mask);
                end
                REG_STATE: begin
                    next_s.rdata[ST_LAMP_ON] = s.lampOnLed;
                    next_s.rdata[ST_ACTIVE] = s.activeLamp;
                    next_s.rdata[ST_SLOT] = slotIn;
                    // panel switch has no say with an accessory
                    next_s.rdata[ST_BRIGHT] = pins.brightness && !slotIn;
                    next_s.rdata[ST_OC] = pins.overCurrent;
                    next_s.rdata[ST_FSM +: $bits(lpcd_fsm_t)] = s.fsm;
                end
                REG_LINEV: begin
                    next_s.rdata = DW'(lineVoltageSample);
                end
                REG_HALF: begin
                    next_s.rdata = DW'(tHalf);
                end
                // unmapped addresses read as zero
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            // an out-of-range phase keeps the triac dark until written
            s.phase <= PHASE_RST;
            s.fsm <= LPCD_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // outputs
    assign rdata = s.rdata;
    // trigger and gate come straight from the timer's flops
    assign triacTrigger = tTrigger;
    assign lampGate = tGate;
    assign mirrorToSecond = s.mirrorToSecond;
    assign mirrorToFirst = s.mirrorToFirst;
    assign lampSelectRelay = s.relay;
    assign secondLampLed = s.led2;
    assign lampOnLed = s.lampOnLed;
    assign reducedSupplyRelay = s.reducedRelay;
    assign irq = s.irq;

endmodule
`default_nettype wire

// ==== test/lpcd_top_props.sv ====
`timescale 1ns/100ps
`default_nettype none

module lpcd_top_props #(
    parameter int RELAY_SETTLE_CYCLES = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // mains side
    input wire logic overCurrent,
    input wire logic triacTrigger,
    input wire logic lampGate,
    // lamp module and slot
    input wire logic mirrorToSecond,
    input wire logic lampSelectRelay,
    input wire logic secondLampLed,
    input wire logic [2:0] slotLines,
    input wire logic reducedSupplyRelay
);
    localparam int LO = RELAY_SETTLE_CYCLES - 2;
    localparam int HI = RELAY_SETTLE_CYCLES + 4;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ==========================================
    // sequences
    sequence s_relay_on;
        $rose(lampSelectRelay);
    endsequence
    sequence s_oc_held;
        overCurrent [*6];
    endsequence
    sequence s_no_slot;
        (slotLines != 3'h0) [*6];
    endsequence

    // ==========================================
    // properties
    property p_trig_pulse;
        triacTrigger |=> !triacTrigger;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse)
        else $error("trigger longer than one cycle");
    property p_gate_on;
        triacTrigger |-> ##[0:1] lampGate;
    endproperty
    a_gate_on: assert property (p_gate_on)
        else $error("gate not on after trigger");
    property p_one_fire;
        triacTrigger |-> !$past(lampGate);
    endproperty
    a_one_fire: assert property (p_one_fire)
        else $error("second firing in one half wave");
    property p_oc_hold;
        s_oc_held |-> !triacTrigger && !lampGate;
    endproperty
    a_oc_hold: assert property (p_oc_hold)
        else $error("lamp driven during overcurrent");
    property p_mirror_first;
        $rose(mirrorToSecond) |-> !lampSelectRelay && !secondLampLed;
    endproperty
    a_mirror_first: assert property (p_mirror_first)
        else $error("mirror moved after relay or led");
    property p_relay_gap;
        s_relay_on |=> (!secondLampLed) [*8];
    endproperty
    a_relay_gap: assert property (p_relay_gap)
        else $error("led lit before relay settled");
    property p_relay_led;
        s_relay_on |-> ##[LO:HI] $rose(secondLampLed);
    endproperty
    a_relay_led: assert property (p_relay_led)
        else $error("led not lit after relay settle");
    property p_slot_relay;
        s_no_slot |-> !reducedSupplyRelay;
    endproperty
    a_slot_relay: assert property (p_slot_relay)
        else $error("supply relay without accessory");
endmodule

bind lpcd_top lpcd_top_props #(.RELAY_SETTLE_CYCLES(RELAY_SETTLE_CYCLES)) u_props (
    .clk, .rst, .overCurrent, .triacTrigger, .lampGate, .mirrorToSecond,
    .lampSelectRelay, .secondLampLed, .slotLines, .reducedSupplyRelay
);

`default_nettype wire

// ==== test/lpcd_mains_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module lpcd_mains_model #(
    parameter int HALF = 4096
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the block
    input wire logic lampGate,
    input wire logic mirrorToSecond,
    input wire logic mirrorToFirst,
    input wire logic lampSelectRelay,
    // fault injection
    input wire logic firstBroken,
    input wire logic shortCircuit,
    // to the block
    output logic zeroCross,
    output logic lampCurrentSense,
    output logic overCurrent,
    output logic mirrorAtSecond
);
    int phaseCnt;
    int mirrorPos;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phaseCnt <= 0;
            zeroCross <= 1'b0;
            mirrorPos <= 0;
        end else begin
            // one level change per half wave
            phaseCnt <= (phaseCnt == HALF - 1) ? 0 : phaseCnt + 1;
            if (phaseCnt == HALF - 1) begin
                zeroCross <= !zeroCross;
            end
            // mirror needs ten cycles of drive to travel
            if (mirrorToSecond && mirrorPos < 10) begin
                mirrorPos <= mirrorPos + 1;
            end else if (mirrorToFirst && mirrorPos > 0) begin
                mirrorPos <= mirrorPos - 1;
            end
        end
    end
    assign mirrorAtSecond = (mirrorPos == 10);
    // current flows only through a conducting intact lamp
    assign lampCurrentSense = lampGate && (lampSelectRelay || !firstBroken);
    assign overCurrent = shortCircuit;
endmodule

`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top import lpcd_pkg::*; ;
    localparam int HALF = 4096;
    typedef struct packed {
        logic [PW-1:0] ph;
        logic fire;
    } lpcd_row_t;
    // phase value and whether it fires inside the half wave
    lpcd_row_t rows [4] = '{
        '{13'h0003, 1'b1},
        '{13'h0ad7, 1'b1},
        '{13'h0e74, 1'b1},
        '{13'h1000, 1'b0}
    };
    logic clk, rst, zeroCross, lampCurrentSense, overCurrent, triacTrigger, lampGate;
    logic mirrorAtSecond, mirrorToSecond, mirrorToFirst, lampSelectRelay, secondLampLed;
    logic lampOnLed, brightnessSwitch, standbyButton, reducedSupplyRelay, irq;
    logic firstBroken, shortCircuit, ok;
    logic [2:0] slotLines;
    logic [7:0] lineVoltageSample;
    logic [DW-1:0] rdata;
    lpcd_bus_t bus;
    int n_fail, check_count, tAt, e;

    lpcd_top #(
        .HALF_WAVE_CYCLES(HALF),
        .RELAY_SETTLE_CYCLES(20),
        .MIRROR_TIMEOUT_CYCLES(50)
    ) DUT (
        .clk, .rst, .bus, .rdata, .zeroCross, .lampCurrentSense, .overCurrent,
        .triacTrigger, .lampGate, .mirrorAtSecond, .mirrorToSecond, .mirrorToFirst,
        .lampSelectRelay, .secondLampLed, .lampOnLed, .slotLines, .brightnessSwitch,
        .standbyButton, .reducedSupplyRelay, .lineVoltageSample, .irq
    );
    lpcd_mains_model #(.HALF(HALF)) mains (
        .clk, .rst, .lampGate, .mirrorToSecond, .mirrorToFirst, .lampSelectRelay,
        .firstBroken, .shortCircuit, .zeroCross, .lampCurrentSense, .overCurrent,
        .mirrorAtSecond
    );

    // ==========================================
    // helpers
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [DW-1:0] near(input int t, input int x);
        return 32'((t > x - 2 && t < x + 2) ? x : t);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic zc();
        @(zeroCross);
        #1;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] x);
        @(posedge clk);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        check(rdata & m, x);
    endtask
    task automatic waitHi(ref logic s, input int n);
        int k;
        k = 0;
        while (s !== 1'b1 && k < n) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    // firing offset and gate hold over one half wave
    task automatic half(output int t, output logic g);
        logic z;
        int d;
        z = zeroCross;
        t = -1;
        g = 1'b1;
        d = 0;
        while (zeroCross === z && d < 2 * HALF) begin
            @(posedge clk);
            #1;
            d++;
            if (triacTrigger === 1'b1) t = d;
            if (t >= 0 && d > t + 1 && zeroCross === z && lampGate !== 1'b1) g = 1'b0;
        end
    endtask
    task automatic press();
        cyc(8);
        @(posedge clk) standbyButton <= 1'b1;
        cyc(8);
        @(posedge clk) standbyButton <= 1'b0;
        cyc(8);
    endtask

    // ==========================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #(24 * HALF * 10);
        n_fail++;
        end_of_test();
    end

    // ==========================================
    // main sequence
    initial begin
        bus = '0;
        rst = 1'b1;
        slotLines = 3'h7;
        brightnessSwitch = 1'b1;
        standbyButton = 1'b0;
        lineVoltageSample = 8'h5a;
        firstBroken = 1'b0;
        shortCircuit = 1'b0;
        n_fail = 0;
        check_count = 0;
        cyc(3);
        check(32'({triacTrigger, lampGate, lampSelectRelay, secondLampLed, irq}), 32'h0);
        @(posedge clk) rst <= 1'b0;
        rchk(REG_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rchk(REG_PHASE, 32'h0000_1fff, 32'h0000_1000);
        rchk(REG_HALF, 32'hffff_ffff, 32'h0000_1000);
        rchk(3'h7, 32'hffff_ffff, 32'h0000_0000);
        rchk(REG_LINEV, 32'h0000_00ff, 32'h0000_005a);
        // zero-cross event, masked then unmasked
        zc();
        cyc(6);
        check(32'(irq), 32'h0);
        rchk(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        wr(REG_MASK, 32'h0000_0001);
        cyc(2);
        check(32'(irq), 32'h1);
        wr(REG_STATUS, 32'h0000_003f);
        cyc(2);
        check(32'(irq), 32'h0);
        wr(REG_MASK, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0001);
        foreach (rows[i]) begin
            wr(REG_PHASE, 32'(rows[i].ph));
            zc();
            e = rows[i].fire ? 4 + int'(rows[i].ph) : -1;
            repeat (2) begin
                half(tAt, ok);
                check(near(tAt, e), 32'(e));
                check(32'(ok), 32'h1);
            end
            cyc(8);
            check(32'(lampOnLed), 32'(rows[i].fire));
        end
        // overcurrent trip in mid half wave
        wr(REG_PHASE, 32'h0000_0064);
        zc();
        cyc(300);
        @(posedge clk) shortCircuit <= 1'b1;
        cyc(8);
        check(32'(lampGate), 32'h0);
        zc();
        half(tAt, ok);
        check(32'(tAt), 32'hffff_ffff);
        rchk(REG_STATUS, 32'h0000_0004, 32'h0000_0004);
        @(posedge clk) shortCircuit <= 1'b0;
        wr(REG_STATUS, 32'h0000_0004);
        zc();
        half(tAt, ok);
        check(near(tAt, 104), 32'h0000_0068);
        // first lamp fails
        @(posedge clk) firstBroken <= 1'b1;
        waitHi(mirrorToSecond, 3 * HALF);
        check(32'({mirrorToSecond, lampSelectRelay, secondLampLed}), 32'h4);
        cyc(5);
        check(32'(lampOnLed), 32'h0);
        waitHi(secondLampLed, 200);
        check(32'({secondLampLed, lampSelectRelay, mirrorAtSecond}), 32'h7);
        rchk(REG_STATUS, 32'h0000_000a, 32'h0000_000a);
        zc();
        half(tAt, ok);
        cyc(8);
        check(32'(lampOnLed), 32'h1);
        @(posedge clk) firstBroken <= 1'b0;
        wr(REG_CTRL, 32'h0000_0009);
        cyc(80);
        check(32'({lampSelectRelay, secondLampLed}), 32'h3);
        wr(REG_CTRL, 32'h0000_0005);
        wr(REG_CTRL, 32'h0000_000d);
        cyc(80);
        check(32'({lampSelectRelay, secondLampLed, mirrorAtSecond}), 32'h0);
        // accessory in the slot, then removed
        wr(REG_CTRL, 32'h0000_0003);
        @(posedge clk) slotLines <= 3'h0;
        press();
        check(32'(reducedSupplyRelay), 32'h1);
        rchk(REG_STATE, 32'h0000_000c, 32'h0000_0004);
        rchk(REG_STATUS, 32'h0000_0010, 32'h0000_0000);
        @(posedge clk) slotLines <= 3'h7;
        press();
        check(32'(reducedSupplyRelay), 32'h0);
        rchk(REG_STATE, 32'h0000_000c, 32'h0000_0008);
        rchk(REG_STATUS, 32'h0000_0010, 32'h0000_0010);
        end_of_test();
    end
endmodule

`default_nettype wire
